// *** test/pio_core_model.sv ***
// core-side model: completer request source and completion sink
// assumes the target's 64-bit stream ports on the shared user clock
`timescale 1ns/1ps
`default_nettype none

module pio_core_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // request stream toward the target
  output logic [63:0]      reqTdata,
  output logic [3:0]       reqFirstBe,
  output logic             reqTlast,
  output logic             reqTvalid,
  input  wire logic        completer_request_ready,
  // completion stream from the target
  input  wire logic [63:0] cplTdata,
  input  wire logic        cplTlast,
  input  wire logic        cplTvalid,
  output logic             cplTready
);
  logic [127:0] cplQ[$];
  logic [63:0]  lowBeat;
  logic         slow = 1'b0;

  initial begin
    reqTdata = 64'h0;
    reqFirstBe = 4'hF;
    reqTlast = 1'b0;
    reqTvalid = 1'b0;
    cplTready = 1'b0;
  end

  // one whole packet; each beat held until ready is seen at an edge
  task automatic send(input logic [255:0] g, input int n,
                      input logic [3:0] be);
    @(posedge clock);
    reqFirstBe <= be;
    for (int k = 0; k < n; k++) begin
      reqTdata  <= g[k*64 +: 64];
      reqTvalid <= 1'b1;
      reqTlast  <= (k == n - 1);
      @(posedge clock);
      for (int t = 0; t < 300 && !completer_request_ready; t++)
        @(posedge clock);
    end
    reqTvalid <= 1'b0;
    // released lines must not keep the last beat
    reqTdata  <= ~g[(n-1)*64 +: 64];
  endtask

  // sink may stall at random; beat 0 is the low half of the word
  always @(posedge clock) begin
    cplTready <= slow ? 1'($urandom_range(1)) : 1'b1;
    if (cplTvalid && cplTready && !cplTlast)
      lowBeat <= cplTdata;
    if (cplTvalid && cplTready && cplTlast)
      cplQ.push_back({cplTdata, lowBeat});
  end
endmodule
`default_nettype wire

// *** test/tb_pio_endpoint_target.sv ***
// self-checking bench for the pio endpoint target, 64-bit datapath
// assumes the core model drives requests and collects completions
`timescale 1ns/1ps
`default_nettype none

module tb_pio_endpoint_target
  import pio_target_pkg::*;
;
  localparam logic [2:0] BARS[4] = '{BAR_IO, BAR_MEM64, BAR_MEM32, BAR_EROM};
  localparam logic [3:0] WTY[4] = '{REQ_IO_WR, REQ_MEM_WR, REQ_MEM_WR,
                                    REQ_MEM_WR};
  localparam logic [3:0] RTY[4] = '{REQ_IO_RD, REQ_MEM_RD, REQ_MEM_RD,
                                    REQ_MEM_RD};
  logic         clock = 1'b0;
  logic         rst_b = 1'b0;
  logic         turnOffRequest = 1'b0;
  logic [63:0]  reqTdata;
  logic [63:0]  cplTdata;
  logic [1:0]   cplTkeep;
  logic [3:0]   reqFirstBe;
  logic         reqTlast;
  logic         reqTvalid;
  logic         completer_request_ready;
  logic         cplTlast;
  logic         cplTvalid;
  logic         cplTready;
  logic         complDone;
  logic         wrBusy;
  logic         turnOffAck;
  logic         rdPend = 1'b0;
  logic [1:0]   beat = 2'h0;
  int           num_errors = 0;
  int           n_compared = 0;
  logic [127:0] expQ[$];
  logic [127:0] mskQ[$];
  logic [1:0]   keepQ[$];

  always #2 clock = ~clock;

  pio_endpoint_target #(.DATA_WIDTH(64), .LINK_LANES(1), .LINK_GEN(1),
                        .USER_CLK_MHZ(250)) i_dut (
    .clock(clock), .rst_b(rst_b), .reqTdata(reqTdata),
    .reqFirstBe(reqFirstBe), .reqTlast(reqTlast), .reqTvalid(reqTvalid),
    .completer_request_ready(completer_request_ready),
    .cplTdata(cplTdata), .cplTkeep(cplTkeep), .cplTlast(cplTlast),
    .cplTvalid(cplTvalid), .cplTready(cplTready), .complDone(complDone),
    .wrBusy(wrBusy), .turnOffRequest(turnOffRequest),
    .turnOffAck(turnOffAck));

  pio_core_model i_core (
    .clock(clock), .rst_b(rst_b), .reqTdata(reqTdata),
    .reqFirstBe(reqFirstBe), .reqTlast(reqTlast), .reqTvalid(reqTvalid),
    .completer_request_ready(completer_request_ready),
    .cplTdata(cplTdata), .cplTlast(cplTlast), .cplTvalid(cplTvalid),
    .cplTready(cplTready));

  task automatic check(string what, logic [127:0] seen, logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // id packs requester id, tag, traffic class, attributes
  function automatic logic [255:0] req_word(logic [3:0] ty, logic [2:0] bar,
      logic [63:0] a, logic [10:0] dw, logic [29:0] id, logic [31:0] d);
    logic [255:0] g;
    g = '0;
    g[63:2] = a[63:2];
    g[DESC_DWCNT_LSB +: 11] = dw;
    g[DESC_TYPE_LSB +: 4] = ty;
    g[DESC_REQID_LSB +: 16] = id[29:14];
    g[DESC_TAG_LSB +: 8] = id[13:6];
    g[DESC_BAR_LSB +: 3] = bar;
    g[DESC_TC_LSB +: 3] = id[5:3];
    g[DESC_ATTR_LSB +: 3] = id[2:0];
    g[PAYLOAD_LSB +: 32] = d;
    return g;
  endfunction

  function automatic logic [127:0] cpl_word(logic [29:0] id, logic [6:0] la,
      logic [12:0] bc, logic [10:0] dw, logic [2:0] st, logic [31:0] d);
    logic [127:0] w;
    w = '0;
    w[CPL_LADDR_LSB +: 7] = la;
    w[CPL_BCNT_LSB +: 13] = bc;
    w[CPL_DWCNT_LSB +: 11] = dw;
    w[CPL_STATUS_LSB +: 3] = st;
    w[CPL_REQID_LSB +: 16] = id[29:14];
    w[CPL_TAG_LSB +: 8] = id[13:6];
    w[CPL_TC_LSB +: 3] = id[5:3];
    w[CPL_ATTR_LSB +: 3] = id[2:0];
    w[CPL_DATA_LSB +: 32] = d;
    return w;
  endfunction

  // lowest enabled byte and enabled span of a first-dword byte enable
  function automatic logic [1:0] be_lo(logic [3:0] be);
    return be[0] ? 2'h0 : be[1] ? 2'h1 : be[2] ? 2'h2 : 2'h3;
  endfunction

  function automatic logic [12:0] be_span(logic [3:0] be);
    return (be[3] ? 13'h4 : be[2] ? 13'h3 : be[1] ? 13'h2 : 13'h1)
           - 13'(be_lo(be));
  endfunction

  task automatic xfer(logic [3:0] ty, logic [2:0] bar, logic [63:0] a,
      logic [10:0] dw, logic [3:0] be, logic [31:0] d);
    logic [29:0] id;
    logic        io;
    id = 30'($urandom);
    io = (ty == REQ_IO_WR);
    i_core.send(req_word(ty, bar, a, dw, id, d), ty[0] ? 3 : 2, be);
    if (dw == ONE_DWORD && ty != REQ_MEM_WR) begin
      expQ.push_back(cpl_word(id, {a[6:2], be_lo(be)},
                     io ? IO_WR_BCNT : be_span(be),
                     io ? 11'h000 : ONE_DWORD, CPL_STATUS_SC,
                     io ? 32'h0 : d));
      mskQ.push_back(cpl_word('1, '1, '1, '1, '1, '1));
      keepQ.push_back(io ? 2'h1 : 2'h3);
    end
  endtask

  task automatic drain(string name);
    logic [127:0] m;
    for (int t = 0; t < 500 && i_core.cplQ.size() < expQ.size(); t++)
      @(posedge clock);
    repeat (8) @(posedge clock);
    check("cpl count", 128'(i_core.cplQ.size()), 128'(expQ.size()));
    while (i_core.cplQ.size() > 0 && expQ.size() > 0) begin
      m = mskQ.pop_front();
      check("cpl", i_core.cplQ.pop_front() & m, expQ.pop_front());
    end
    i_core.cplQ.delete();
    expQ.delete();
    mskQ.delete();
    keepQ.delete();
    $display("test %s done", name);
  endtask

  // request side must stay stalled while a read or write is in flight
  always @(posedge clock) begin
    if (rdPend)
      check("ready in read", 128'(completer_request_ready), 128'h0);
    if (wrBusy)
      check("ready in write", 128'(completer_request_ready), 128'h0);
    if (cplTvalid && cplTready && cplTlast)
      check("keep last", 128'(cplTkeep), 128'(keepQ.pop_front()));
    else if (cplTvalid && cplTready)
      check("keep first", 128'(cplTkeep), 128'h3);
    if (complDone)
      rdPend <= 1'b0;
    else if (reqTvalid && completer_request_ready && reqTlast &&
             beat == 2'h1 && !reqTdata[11])
      rdPend <= 1'b1;
    if (reqTvalid && completer_request_ready)
      beat <= reqTlast ? 2'h0 : beat + 2'h1;
  end

  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end

  initial begin
    logic [63:0] a;
    logic [31:0] d[4];
    logic [3:0]  be;
    void'($urandom(32'h33C2));
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    for (int it = 0; it < 6; it++) begin
      i_core.slow = it[0];
      a = {53'h0, 9'($urandom), 2'b00};
      if (it < 2)
        a[10:2] = it[0] ? 9'h1FF : 9'h000;
      for (int r = 0; r < 4; r++) begin
        d[r] = $urandom;
        xfer(WTY[r], BARS[r], a, ONE_DWORD, 4'hF, d[r]);
      end
      xfer(REQ_MEM_WR, BAR_MEM32, a, 11'h002, 4'hF, ~d[2]);
      drain("writes");
      // back-to-back reads with the address offset by it times 2 KB
      for (int r = 0; r < 4; r++) begin
        be = 4'($urandom_range(15, 1));
        xfer(RTY[r], BARS[r], a | (64'(it) << 11), ONE_DWORD, be,
             d[r]);
      end
      drain("reads");
    end
    turnOffRequest <= 1'b1;
    repeat (3) @(posedge clock);
    #1 check("turn-off ack", 128'(turnOffAck), 128'h1);
    @(posedge clock);
    turnOffRequest <= 1'b0;
    repeat (3) @(posedge clock);
    #1 check("turn-off idle", 128'(turnOffAck), 128'h0);
    $display("test turn-off done");
    wrap_up();
  end
endmodule
`default_nettype wire

// *** verilog/pio_endpoint_target.sv ***
// programmed-i/o target behind the endpoint core: four 2 KB regions
// assumes core user clock and reset; streams come from logic on that clock
//
// Behaviour
// [R1] The bar hit index picks the 2 KB region before the memory is touched.
// [R2] Bar hit index 010b selects the 32-bit memory region.
// [R3] A memory read takes the low address bits and starts the memory read.
// [R4] Every accepted memory or i/o read is answered by a completion with data.
// [R5] Ready stays low while a read runs until its completion is sent.
// [R6] Ready drops after the last beat and returns once the completion is sent.
// [R7] The next write is taken only after the write-busy flag falls.
// [R8] The stream datapath is 64, 128 or 256 bits, chosen at build time.
// [R9] Datapath width must suit the lane count: x1 64, x2 up to 128, else all.
// [R10] 128 bits is refused for eight gen3 lanes with a 500 MHz user clock.
// [R11] The block has receive, transmit, memory access and turn-off parts.
// [R12] The core gives the bar hit index in descriptor bits 114 to 112.
// [R13] Reads get a one-dword completion, i/o writes a dataless success.
// [R14] Requests longer than one dword are taken in full and dropped silently.
// [R15] Addresses past 2 KB wrap onto the same region.
// [R16] Completions copy requester id, tag, traffic class and attributes.
`timescale 1ns/1ps
`default_nettype none

module pio_endpoint_target
  import pio_target_pkg::*;
#(
  parameter int DATA_WIDTH   = 64,
  parameter int LINK_LANES   = 1,
  parameter int LINK_GEN     = 1,
  parameter int USER_CLK_MHZ = 250
) (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_b,
  // completer request stream
  input  wire logic [DATA_WIDTH-1:0]   reqTdata,
  input  wire logic [3:0]              reqFirstBe,
  input  wire logic                    reqTlast,
  input  wire logic                    reqTvalid,
  output logic                         completer_request_ready,
  // completer completion stream
  output logic [DATA_WIDTH-1:0]        cplTdata,
  output logic [DATA_WIDTH/32-1:0]     cplTkeep,
  output logic                         cplTlast,
  output logic                         cplTvalid,
  input  wire logic                    cplTready,
  // status
  output logic                         complDone,
  output logic                         wrBusy,
  // power management
  input  wire logic                    turnOffRequest,
  output logic                         turnOffAck
);

  localparam int KEEP_W       = DATA_WIDTH / 32;
  localparam int GATHER_BEATS = GATHER_W / DATA_WIDTH;
  localparam int CPL_BEATS    = (DATA_WIDTH == 64) ? 2 : 1;
  localparam int PAD_W        = CPL_BEATS * DATA_WIDTH;
  localparam int PAD_KEEP     = PAD_W / 32;

  // build-time checks
  if (DATA_WIDTH != 64 && DATA_WIDTH != 128 && DATA_WIDTH != 256) begin : g_w
    $error("datapath must be 64, 128 or 256 bits"); // [R8]
  end
  if (LINK_LANES == 1 && DATA_WIDTH != 64) begin : g_x1
    $error("one lane allows only a 64-bit datapath"); // [R9]
  end
  if (LINK_LANES == 2 && DATA_WIDTH == 256) begin : g_x2
    $error("two lanes allow 64 or 128 bits"); // [R9]
  end
  if (LINK_LANES != 1 && LINK_LANES != 2 && LINK_LANES != 4
      && LINK_LANES != 8) begin : g_lanes
    $error("lane count must be 1, 2, 4 or 8"); // [R9]
  end
  if (LINK_LANES == 8 && LINK_GEN == 3 && USER_CLK_MHZ == 500
      && DATA_WIDTH == 128) begin : g_x8
    $error("128 bits unsupported for x8 gen3 at 500 MHz"); // [R10]
  end

  // helpers
  function automatic logic [2:0] regionOf(input logic [2:0] bar);
    case (bar)
      BAR_IO:    regionOf = {1'b1, REGION_IO};
      BAR_MEM64: regionOf = {1'b1, REGION_MEM64};
      BAR_MEM32: regionOf = {1'b1, REGION_MEM32};
      BAR_EROM:  regionOf = {1'b1, REGION_EROM};
      default:   regionOf = 3'h0;
    endcase
  endfunction

  function automatic logic [1:0] lowByte(input logic [3:0] be);
    casez (be)
      4'b???1: lowByte = 2'h0;
      4'b??10: lowByte = 2'h1;
      4'b?100: lowByte = 2'h2;
      4'b1000: lowByte = 2'h3;
      default: lowByte = 2'h0;
    endcase
  endfunction

  function automatic logic [12:0] beBytes(input logic [3:0] be);
    casez (be)
      4'b1??1: beBytes = 13'h0004;
      4'b01?1: beBytes = 13'h0003;
      4'b1?10: beBytes = 13'h0003;
      4'b0011: beBytes = 13'h0002;
      4'b0110: beBytes = 13'h0002;
      4'b1100: beBytes = 13'h0002;
      default: beBytes = 13'h0001;
    endcase
  endfunction

  function automatic logic [CPL_W-1:0] buildCpl(
    input reqInfo_t    r,
    input logic [3:0]  be,
    input logic [31:0] data,
    input logic        withData
  );
    logic [CPL_W-1:0] w;
    w = '0;
    w[CPL_LADDR_LSB +: 7]   = {r.lowAddr, lowByte(be)};
    w[CPL_BCNT_LSB +: 13]   = withData ? beBytes(be) : IO_WR_BCNT;
    w[CPL_DWCNT_LSB +: 11]  = withData ? ONE_DWORD : 11'h000; // [R13]
    w[CPL_STATUS_LSB +: 3]  = CPL_STATUS_SC;
    w[CPL_REQID_LSB +: 16]  = r.reqId; // [R16]
    w[CPL_TAG_LSB +: 8]     = r.tag; // [R16]
    w[CPL_TC_LSB +: 3]      = r.tc; // [R16]
    w[CPL_ATTR_LSB +: 3]    = r.attr; // [R16]
    w[CPL_DATA_LSB +: 32]   = withData ? data : 32'h0000_0000;
    return w;
  endfunction

  function automatic logic [PAD_KEEP-1:0] keepMask(input logic [2:0] dws);
    logic [PAD_KEEP-1:0] m;
    m = '0;
    for (int i = 0; i < PAD_KEEP; i++) begin
      m[i] = (i < int'(dws));
    end
    return m;
  endfunction

  state_t                 state;
  state_t                 next_state;
  logic [GATHER_W-1:0]    gather;
  logic [2:0]             beatIdx;
  logic [3:0]             firstBe;
  logic [CPL_W-1:0]       cplWord;
  logic [2:0]             cplDwords;
  logic                   cplBeat;
  logic [31:0]            mem [MEM_WORDS];
  reqInfo_t               info;

  // receive engine: descriptor decode from gathered beats
  wire reqFire = reqTvalid && completer_request_ready;
  assign info.reqType = gather[DESC_TYPE_LSB +: 4];
  assign info.barHit  = gather[DESC_BAR_LSB +: 3]; // [R12]
  assign info.dwCount = gather[DESC_DWCNT_LSB +: 11];
  assign info.wordIdx = gather[DESC_ADDR_LSB +: REGION_IDX_W]; // [R3] [R15]
  assign info.lowAddr = gather[DESC_ADDR_LSB +: 5];
  assign info.reqId   = gather[DESC_REQID_LSB +: 16];
  assign info.tag     = gather[DESC_TAG_LSB +: 8];
  assign info.tc      = gather[DESC_TC_LSB +: 3];
  assign info.attr    = gather[DESC_ATTR_LSB +: 3];
  assign info.payload = gather[PAYLOAD_LSB +: 32];

  wire [2:0] regionSel = regionOf(info.barHit); // [R1] [R2]
  wire isRead  = info.reqType == REQ_MEM_RD || info.reqType == REQ_IO_RD;
  wire isWrite = info.reqType == REQ_MEM_WR || info.reqType == REQ_IO_WR;
  wire accept  = info.dwCount == ONE_DWORD && regionSel[2]
                 && (isRead || isWrite); // [R14]
  wire [MEM_IDX_W-1:0] memIdx = {regionSel[1:0], info.wordIdx}; // [R1]
  wire [31:0] rdWord = mem[memIdx];

  // one request at a time; ready only in ST_RECV
  assign completer_request_ready = state == ST_RECV; // [R5] [R6] [R7]
  assign wrBusy    = state == ST_WRITE;
  assign cplTvalid = state == ST_SEND;
  assign cplTlast  = cplBeat == 1'(CPL_BEATS - 1);
  assign complDone = cplTvalid && cplTready && cplTlast;

  always_comb begin
    next_state = state;
    case (state)
      ST_RECV:   if (reqFire && reqTlast) next_state = ST_DECODE; // [R6]
      ST_DECODE: begin
        if (!accept) next_state = ST_RECV; // [R14]
        else if (isWrite) next_state = ST_WRITE;
        else next_state = ST_READ; // [R3]
      end
      ST_WRITE:  begin
        if (info.reqType == REQ_IO_WR) next_state = ST_SEND; // [R13]
        else next_state = ST_RECV; // [R7]
      end
      ST_READ:   next_state = ST_SEND; // [R4]
      ST_SEND:   if (complDone) next_state = ST_RECV; // [R5] [R6]
      default:   next_state = ST_RECV;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) state <= ST_RECV; // [R11]
    else state <= next_state;
  end

  // beat gathering; extra payload beats past the window are discarded
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      beatIdx <= 3'h0;
      firstBe <= 4'h0;
      gather  <= '0;
    end else if (reqFire) begin
      if (beatIdx == 3'h0) firstBe <= reqFirstBe;
      if (beatIdx < 3'(GATHER_BEATS))
        gather[beatIdx*DATA_WIDTH +: DATA_WIDTH] <= reqTdata;
      if (reqTlast) beatIdx <= 3'h0; // [R14]
      else if (beatIdx < 3'(GATHER_BEATS)) beatIdx <= beatIdx + 3'h1;
    end
  end

  // memory access controller
  always_ff @(posedge clock) begin
    if (state == ST_WRITE) begin
      for (int b = 0; b < 4; b++) begin
        if (firstBe[b]) mem[memIdx][8*b +: 8] <= info.payload[8*b +: 8];
      end
    end
  end

  // transmit engine
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cplWord   <= '0;
      cplDwords <= 3'h0;
    end else if (state == ST_READ) begin
      cplWord   <= buildCpl(info, firstBe, rdWord, 1'b1); // [R4] [R13]
      cplDwords <= CPL_DW_DATA;
    end else if (state == ST_WRITE) begin
      cplWord   <= buildCpl(info, firstBe, rdWord, 1'b0); // [R13]
      cplDwords <= CPL_DW_NODATA;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) cplBeat <= 1'b0;
    else if (cplTvalid && cplTready) cplBeat <= cplTlast ? 1'b0 : 1'b1;
  end

  wire [PAD_W-1:0]    cplPadded = PAD_W'(cplWord);
  wire [PAD_KEEP-1:0] keepAll   = keepMask(cplDwords);
  assign cplTdata = cplPadded[cplBeat*DATA_WIDTH +: DATA_WIDTH];
  assign cplTkeep = keepAll[cplBeat*KEEP_W +: KEEP_W];

  // turn-off controller: acknowledge only in ST_RECV with no beat gathered
  wire idle = state == ST_RECV && beatIdx == 3'h0;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) turnOffAck <= 1'b0;
    else if (!turnOffRequest) turnOffAck <= 1'b0;
    else if (idle) turnOffAck <= 1'b1; // [R11]
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_ready_drop: assert property ( // [R6]
    reqFire && reqTlast |=> !completer_request_ready
      ##1 completer_request_ready == !$past(accept))
    else $error("ready not dropped after last beat");
  a_read_answer: assert property ( // [R4]
    state == ST_DECODE && accept && isRead |=> !cplTvalid ##1 cplTvalid)
    else $error("read not answered two cycles after decode");
  a_read_hold: assert property ( // [R5]
    cplTvalid && !complDone |=> !completer_request_ready)
    else $error("ready rose before completion was sent");
  a_done_reopen: assert property ( // [R6]
    complDone |=> completer_request_ready)
    else $error("ready not back after completion");
  a_write_gate: assert property ( // [R7]
    wrBusy |-> !completer_request_ready ##1
      (completer_request_ready || cplTvalid) && !wrBusy)
    else $error("write gating wrong");
  a_drop_silent: assert property ( // [R14]
    state == ST_DECODE && !accept |=> completer_request_ready && !cplTvalid)
    else $error("oversized request not dropped");
  a_region_pick: assert property ( // [R2]
    state == ST_DECODE && info.barHit == BAR_MEM32
      |-> memIdx[MEM_IDX_W-1 -: 2] == REGION_MEM32)
    else $error("mem32 hit not steered to its region");
  a_addr_wrap: assert property ( // [R15]
    state == ST_DECODE
      |-> memIdx[REGION_IDX_W-1:0] == gather[DESC_ADDR_LSB +: REGION_IDX_W])
    else $error("address not wrapped into region");
  a_read_data: assert property ( // [R3]
    state == ST_READ |=> cplWord[CPL_DATA_LSB +: 32] == $past(rdWord))
    else $error("completion data is not the addressed word");
  a_cpl_ident: assert property ( // [R16]
    cplTvalid |-> cplWord[CPL_TAG_LSB +: 8] == info.tag
      && cplWord[CPL_REQID_LSB +: 16] == info.reqId)
    else $error("completion identity differs from request");
  a_iowr_nodata: assert property ( // [R13]
    state == ST_WRITE && info.reqType == REQ_IO_WR
      |=> cplTvalid && cplWord[CPL_DWCNT_LSB +: 11] == 11'h000)
    else $error("i/o write completion wrong");
  a_cpl_stable: assert property (
    cplTvalid && !cplTready |=> cplTvalid && $stable(cplTdata))
    else $error("completion changed while stalled");

endmodule

`default_nettype wire

// *** verilog/pio_target_pkg.sv ***
// constants, request carrier and state type for the pio endpoint target
// assumes the core's completer request and completion stream layouts
package pio_target_pkg;

  // request descriptor fields
  localparam int GATHER_W          = 256;
  localparam int DESC_ADDR_LSB     = 2;
  localparam int DESC_DWCNT_LSB    = 64;
  localparam int DESC_TYPE_LSB     = 75;
  localparam int DESC_REQID_LSB    = 80;
  localparam int DESC_TAG_LSB      = 96;
  localparam int DESC_BAR_LSB      = 112;
  localparam int DESC_TC_LSB       = 121;
  localparam int DESC_ATTR_LSB     = 124;
  localparam int PAYLOAD_LSB       = 128;

  // request types
  localparam logic [3:0] REQ_MEM_RD = 4'h0;
  localparam logic [3:0] REQ_MEM_WR = 4'h1;
  localparam logic [3:0] REQ_IO_RD  = 4'h2;
  localparam logic [3:0] REQ_IO_WR  = 4'h3;

  // bar hit index values and the regions they select
  localparam logic [2:0] BAR_IO      = 3'h0;
  localparam logic [2:0] BAR_MEM64   = 3'h1;
  localparam logic [2:0] BAR_MEM32   = 3'h2;
  localparam logic [2:0] BAR_EROM    = 3'h6;
  localparam logic [1:0] REGION_IO    = 2'h0;
  localparam logic [1:0] REGION_MEM64 = 2'h1;
  localparam logic [1:0] REGION_MEM32 = 2'h2;
  localparam logic [1:0] REGION_EROM  = 2'h3;

  // memory geometry
  localparam int REGION_BYTES  = 2048;
  localparam int WORD_BYTES    = 4;
  localparam int REGION_WORDS  = REGION_BYTES / WORD_BYTES;
  localparam int REGIONS       = 4;
  localparam int MEM_WORDS     = REGIONS * REGION_WORDS;
  localparam int REGION_IDX_W  = 9;
  localparam int MEM_IDX_W     = 11;

  // completion descriptor fields
  localparam int CPL_W          = 128;
  localparam int CPL_LADDR_LSB  = 0;
  localparam int CPL_BCNT_LSB   = 16;
  localparam int CPL_DWCNT_LSB  = 32;
  localparam int CPL_STATUS_LSB = 43;
  localparam int CPL_REQID_LSB  = 48;
  localparam int CPL_TAG_LSB    = 64;
  localparam int CPL_TC_LSB     = 89;
  localparam int CPL_ATTR_LSB   = 92;
  localparam int CPL_DATA_LSB   = 96;
  localparam logic [2:0]  CPL_STATUS_SC = 3'h0;
  localparam logic [12:0] IO_WR_BCNT    = 13'h0004;
  localparam logic [10:0] ONE_DWORD     = 11'h001;
  localparam logic [2:0]  CPL_DW_DATA   = 3'h4;
  localparam logic [2:0]  CPL_DW_NODATA = 3'h3;

  typedef struct packed {
    logic [3:0]  reqType;
    logic [2:0]  barHit;
    logic [10:0] dwCount;
    logic [8:0]  wordIdx;
    logic [4:0]  lowAddr;
    logic [15:0] reqId;
    logic [7:0]  tag;
    logic [2:0]  tc;
    logic [2:0]  attr;
    logic [31:0] payload;
  } reqInfo_t;

  typedef enum {ST_RECV, ST_DECODE, ST_WRITE, ST_READ, ST_SEND} state_t;

endpackage
